// *** gbm_pkg.sv ***
// Constants, field layout and types shared by the peripheral bus master
package gbm_pkg;
   // Slave bus geometry
   localparam int GBM_SLAVES = 4;
   localparam int GBM_DATA_W = 8;
   localparam int GBM_REG_W = 3;
   localparam int GBM_ID_W = 2;
   localparam int GBM_WORD_W = 32;
   localparam int GBM_CNT_W = 6;
   // Selectable strobe width and recovery, in system clocks
   localparam logic [5:0] GBM_CLKS_SEL0 = 6'h03;
   localparam logic [5:0] GBM_CLKS_SEL1 = 6'h04;
   localparam logic [5:0] GBM_CLKS_SEL2 = 6'h0c;
   localparam logic [5:0] GBM_CLKS_SEL3 = 6'h0f;
   // Longest strobe, wait states included, and the count step
   localparam logic [5:0] GBM_ABORT_CLKS = 6'h20;
   localparam logic [5:0] GBM_CNT_ONE = 6'h01;
   // Slave mailbox field positions
   localparam int GBM_MB_BYTE_LSB = 0;
   localparam int GBM_MB_REG_LSB = 8;
   localparam int GBM_MB_ID_LSB = 12;
   localparam int GBM_MB_DIR_BIT = 16;
   localparam int GBM_MB_PEND_BIT = 24;
   localparam int GBM_MB_TO_BIT = 25;
   // Reset values and the index of a word's last byte
   localparam logic [3:0] GBM_CS_IDLE = 4'hf;
   localparam logic [7:0] GBM_BYTE_RST = 8'h00;
   localparam logic [1:0] GBM_LAST_BYTE = 2'h3;

   // Bus cycle sequencer states
   typedef enum logic [2:0] {
      GBM_IDLE = 3'b000,
      GBM_SETUP = 3'b001,
      GBM_STROBE = 3'b010,
      GBM_HOLD = 3'b011,
      GBM_RECOV = 3'b100
   } gbm_state_t;

   // Decode a 2-bit timing selector into clocks
   function automatic logic [5:0] gbm_clks(input logic [1:0] sel);
      logic [5:0] r;
      r = GBM_CLKS_SEL0;
      unique case (sel)
         2'h0: r = GBM_CLKS_SEL0;
         2'h1: r = GBM_CLKS_SEL1;
         2'h2: r = GBM_CLKS_SEL2;
         2'h3: r = GBM_CLKS_SEL3;
      endcase
      return r;
   endfunction : gbm_clks
endpackage : gbm_pkg

// *** gbm_buf2.sv ***
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module gbm_buf2
   import gbm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [GBM_WORD_W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [GBM_WORD_W-1:0] out_data
);
   typedef struct packed {
      logic [1:0][GBM_WORD_W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
      logic rdy;
   } gbm_buf_t;

   gbm_buf_t s_q, s_d;
   logic push, pop;

   // Handshakes on both sides
   assign push = in_valid && s_q.rdy;
   assign pop = out_ready && (s_q.cnt != 2'h0);

   // Next buffer state
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = ~s_q.wp;
      end
      if (pop) begin
         s_d.rp = ~s_q.rp;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
      s_d.rdy = (s_d.cnt != 2'h2);
   end

   // State register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign in_ready = s_q.rdy;
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data = s_q.mem[s_q.rp];
endmodule : gbm_buf2
`default_nettype wire

// *** gbm_master.sv ***
// Peripheral byte bus master with code streaming and slave mailbox
//
// Contract
// - Each slave has its own strobe width and recovery setting.
// - Strobes stay inactive for the slave's recovery after each access.
// - Width and recovery count clocks, selectable as 3, 4, 12 or 15.
// - Code write starts only with data buffered, no mailbox, ready high.
// - Each code write sends one buffered byte to the stream target.
// - Code and mailbox cycles use the target slave's own timing.
// - Code words go out least significant byte first.
// - A pending mailbox runs after the current code write, before more.
// - Mailbox direction one means write to the slave.
// - Mailbox targets slave id 0..3 and register 0..7.
// - Mailbox completion clears the pending bit.
// - Mailbox write drives the low mailbox byte onto the bus.
// - Mailbox read captures the slave byte into the low mailbox byte.
// - Wait input is sampled only once the strobe width has elapsed.
// - Wait released and width elapsed: latch, release strobe, recover.
// - Wait states are honoured in code writes and mailbox cycles.
// - A strobe active for 32 clocks aborts the cycle.
// - Abort sets mailbox timeout and clears pending, or stream timeout.
// - Select and address lead strobe by one clock; select trails by one, address holds.
// - A host write covering the data byte sets pending.
// - Bus has 8 data, 3 address, 4 selects, two strobes, wait.
`timescale 1ns/1ps
`default_nettype none
module gbm_master
   import gbm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Slave mailbox register port
   input wire logic mbox_wr,
   input wire logic [3:0] mbox_be,
   input wire logic [GBM_WORD_W-1:0] mbox_wdata,
   output logic [GBM_WORD_W-1:0] mbox_rdata,
   // Per-slave timing selectors, two bits per slave
   input wire logic [2*GBM_SLAVES-1:0] strobe_width,
   input wire logic [2*GBM_SLAVES-1:0] strobe_recovery,
   // Code stream target and words
   input wire logic [GBM_ID_W-1:0] stream_target_id,
   input wire logic [GBM_REG_W-1:0] stream_target_reg,
   input wire logic code_valid,
   output logic code_ready,
   input wire logic [GBM_WORD_W-1:0] code_word,
   output logic stream_timeout,
   input wire logic stream_timeout_clr,
   // Peripheral byte bus
   output logic [GBM_SLAVES-1:0] slave_select_n,
   output logic [GBM_REG_W-1:0] slave_reg_addr,
   output logic read_strobe_n,
   output logic write_strobe_n,
   input wire logic [GBM_DATA_W-1:0] slave_data_i,
   output logic [GBM_DATA_W-1:0] slave_data_o,
   output logic slave_data_oe,
   input wire logic slave_wait_n,
   input wire logic slave_ready_in
);
   typedef struct packed {
      gbm_state_t st;
      logic [GBM_CNT_W-1:0] cnt;
      logic is_mbox;
      logic is_rd;
      logic [GBM_ID_W-1:0] sel;
      logic [1:0] byte_idx;
      logic [GBM_DATA_W-1:0] mb_byte;
      logic [GBM_REG_W-1:0] mb_reg;
      logic [GBM_ID_W-1:0] mb_id;
      logic mb_dir;
      logic mb_pend;
      logic mb_to;
      logic str_to;
      logic [1:0] wait_sy;
      logic [1:0] rdy_sy;
      logic [1:0][GBM_DATA_W-1:0] dat_sy;
      logic [GBM_SLAVES-1:0] cs_n;
      logic [GBM_REG_W-1:0] addr;
      logic rd_n;
      logic wr_n;
      logic [GBM_DATA_W-1:0] dout;
      logic doe;
      logic [GBM_WORD_W-1:0] rdata;
   } gbm_master_t;

   gbm_master_t s_q, s_d;
   logic buf_valid, buf_pop;
   logic [GBM_WORD_W-1:0] buf_word;
   logic [GBM_CNT_W-1:0] width_clks, rec_clks;
   logic [GBM_DATA_W-1:0] code_byte;

   // Code words wait here; a stalled bus back-pressures the source
   gbm_buf2 u_code_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(code_valid),
      .in_ready(code_ready),
      .in_data(code_word),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_word)
   );

   // Timing of the slave now addressed
   assign width_clks = gbm_clks(strobe_width[2*s_q.sel +: 2]);
   assign rec_clks = gbm_clks(strobe_recovery[2*s_q.sel +: 2]);
   assign code_byte = buf_word[GBM_DATA_W*s_q.byte_idx +: GBM_DATA_W];
   // Last byte of a word leaves the buffer when its cycle ends
   assign buf_pop = (s_q.st == GBM_HOLD) && !s_q.is_mbox &&
                    (s_q.byte_idx == GBM_LAST_BYTE);

   // Next state of the whole master
   always_comb begin
      s_d = s_q;
      // Pins pass two flops before use
      s_d.wait_sy = {s_q.wait_sy[0], slave_wait_n};
      s_d.rdy_sy = {s_q.rdy_sy[0], slave_ready_in};
      s_d.dat_sy = {s_q.dat_sy[0], slave_data_i};
      unique case (s_q.st)
         GBM_IDLE: begin
            if (s_q.mb_pend) begin
               s_d.is_mbox = 1'b1;
               s_d.is_rd = !s_q.mb_dir;
               s_d.sel = s_q.mb_id;
               s_d.addr = s_q.mb_reg;
               s_d.dout = s_q.mb_byte;
               s_d.doe = s_q.mb_dir;
               s_d.cs_n = ~(4'h1 << s_q.mb_id);
               s_d.st = GBM_SETUP;
            end else if (buf_valid && s_q.rdy_sy[1]) begin
               s_d.is_mbox = 1'b0;
               s_d.is_rd = 1'b0;
               s_d.sel = stream_target_id;
               s_d.addr = stream_target_reg;
               s_d.dout = code_byte;
               s_d.doe = 1'b1;
               s_d.cs_n = ~(4'h1 << stream_target_id);
               s_d.st = GBM_SETUP;
            end
         end
         GBM_SETUP: begin
            // Strobe one clock after select and address
            s_d.rd_n = !s_q.is_rd;
            s_d.wr_n = s_q.is_rd;
            s_d.cnt = GBM_CNT_ONE;
            s_d.st = GBM_STROBE;
         end
         GBM_STROBE: begin
            if (s_q.cnt == GBM_ABORT_CLKS) begin
               s_d.rd_n = 1'b1;
               s_d.wr_n = 1'b1;
               s_d.st = GBM_HOLD;
               if (s_q.is_mbox) begin
                  s_d.mb_to = 1'b1;
                  s_d.mb_pend = 1'b0;
               end else begin
                  s_d.str_to = 1'b1;
               end
            end else if (s_q.cnt >= width_clks && s_q.wait_sy[1]) begin
               // Wait released and width met: end the strobe
               s_d.rd_n = 1'b1;
               s_d.wr_n = 1'b1;
               s_d.st = GBM_HOLD;
               if (s_q.is_mbox) begin
                  s_d.mb_pend = 1'b0;
                  if (s_q.is_rd) begin
                     s_d.mb_byte = s_q.dat_sy[1];
                  end
               end
            end else begin
               s_d.cnt = s_q.cnt + GBM_CNT_ONE;
            end
         end
         GBM_HOLD: begin
            // Release select and data drive one clock after the strobe; address holds
            s_d.cs_n = GBM_CS_IDLE;
            s_d.doe = 1'b0;
            s_d.cnt = GBM_CNT_ONE;
            if (!s_q.is_mbox) begin
               s_d.byte_idx = s_q.byte_idx + 2'h1;
            end
            s_d.st = GBM_RECOV;
         end
         GBM_RECOV: begin
            if (s_q.cnt >= rec_clks) begin
               s_d.st = GBM_IDLE;
            end else begin
               s_d.cnt = s_q.cnt + GBM_CNT_ONE;
            end
         end
         default: begin
            s_d.st = GBM_IDLE;
         end
      endcase
      // Host side of the stream timeout; a new timeout wins
      if (stream_timeout_clr && !(s_d.str_to && !s_q.str_to)) begin
         s_d.str_to = 1'b0;
      end
      // Host mailbox writes; the set of pending wins over completion
      if (mbox_wr) begin
         if (mbox_be[0]) begin
            s_d.mb_byte = mbox_wdata[GBM_MB_BYTE_LSB +: GBM_DATA_W];
            s_d.mb_pend = 1'b1;
            s_d.mb_to = s_d.mb_to && !s_q.mb_to; // New abort wins
         end
         if (mbox_be[1]) begin
            s_d.mb_reg = mbox_wdata[GBM_MB_REG_LSB +: GBM_REG_W];
            s_d.mb_id = mbox_wdata[GBM_MB_ID_LSB +: GBM_ID_W];
         end
         if (mbox_be[2]) begin
            s_d.mb_dir = mbox_wdata[GBM_MB_DIR_BIT];
         end
      end
      // Readback image of the mailbox
      s_d.rdata = '0;
      s_d.rdata[GBM_MB_BYTE_LSB +: GBM_DATA_W] = s_d.mb_byte;
      s_d.rdata[GBM_MB_REG_LSB +: GBM_REG_W] = s_d.mb_reg;
      s_d.rdata[GBM_MB_ID_LSB +: GBM_ID_W] = s_d.mb_id;
      s_d.rdata[GBM_MB_DIR_BIT] = s_d.mb_dir;
      s_d.rdata[GBM_MB_PEND_BIT] = s_d.mb_pend;
      s_d.rdata[GBM_MB_TO_BIT] = s_d.mb_to;
   end

   // State register
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= GBM_IDLE;
         s_q.cs_n <= GBM_CS_IDLE;
         s_q.rd_n <= 1'b1;
         s_q.wr_n <= 1'b1;
         s_q.wait_sy <= 2'h3;
         s_q.dout <= GBM_BYTE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign slave_select_n = s_q.cs_n;
   assign slave_reg_addr = s_q.addr;
   assign read_strobe_n = s_q.rd_n;
   assign write_strobe_n = s_q.wr_n;
   assign slave_data_o = s_q.dout;
   assign slave_data_oe = s_q.doe;
   assign mbox_rdata = s_q.rdata;
   assign stream_timeout = s_q.str_to;

   // Checks on the bus sequence
   logic strobe_idle;
   assign strobe_idle = s_q.rd_n && s_q.wr_n;

   property p_cs_leads;
      @(posedge sys_clk) disable iff (sys_rst)
      $fell(strobe_idle) |-> $past(s_q.cs_n) == s_q.cs_n &&
         $past(s_q.cs_n, 2) == GBM_CS_IDLE;
   endproperty
   a_cs_leads: assert property (p_cs_leads)
      else $error("strobe not one clock after select");

   property p_cs_trails;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(strobe_idle) |-> s_q.cs_n != GBM_CS_IDLE ##1
         s_q.cs_n == GBM_CS_IDLE;
   endproperty
   a_cs_trails: assert property (p_cs_trails)
      else $error("select not released one clock after strobe");

   property p_one_select;
      @(posedge sys_clk) disable iff (sys_rst)
      s_q.cs_n != GBM_CS_IDLE |-> $onehot(~s_q.cs_n);
   endproperty
   a_one_select: assert property (p_one_select)
      else $error("more than one select active");

   property p_abort;
      @(posedge sys_clk) disable iff (sys_rst)
      s_q.st == GBM_STROBE |-> s_q.cnt <= GBM_ABORT_CLKS;
   endproperty
   a_abort: assert property (p_abort)
      else $error("strobe held past abort limit");

   property p_width;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(strobe_idle) |-> $past(s_q.cnt) >= width_clks;
   endproperty
   a_width: assert property (p_width)
      else $error("strobe shorter than configured width");

   property p_recov;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_q.st == GBM_RECOV && s_q.cnt < rec_clks) |=> s_q.st == GBM_RECOV;
   endproperty
   a_recov: assert property (p_recov)
      else $error("recovery cut short");

   property p_pend_set;
      @(posedge sys_clk) disable iff (sys_rst)
      (mbox_wr && mbox_be[0]) |=> s_q.mb_pend ##1 s_q.rdata[GBM_MB_PEND_BIT];
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("pending not set by data byte write");

   property p_mbox_first;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_q.st == GBM_IDLE && s_q.mb_pend) |=>
         s_q.st == GBM_SETUP && s_q.is_mbox;
   endproperty
   a_mbox_first: assert property (p_mbox_first)
      else $error("mailbox request not served first");

   property p_mbox_data;
      @(posedge sys_clk) disable iff (sys_rst)
      (s_q.st == GBM_STROBE && s_q.is_mbox && !s_q.is_rd) |->
         s_q.doe && !s_q.wr_n && s_q.rd_n;
   endproperty
   a_mbox_data: assert property (p_mbox_data)
      else $error("mailbox write not driving bus");

   property p_done_clears;
      @(posedge sys_clk) disable iff (sys_rst)
      ($rose(strobe_idle) && s_q.is_mbox && !$past(mbox_wr)) |->
         !s_q.mb_pend;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("pending not cleared at completion");

   c_code_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(strobe_idle) && !s_q.is_mbox);
   c_mbox_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(strobe_idle) && s_q.is_mbox && s_q.is_rd);
   c_abort: cover property (@(posedge sys_clk) disable iff (sys_rst)
      s_q.st == GBM_STROBE && s_q.cnt == GBM_ABORT_CLKS);
endmodule : gbm_master
`default_nettype wire

// *** gbm_slave_model.sv ***
// Behavioural slave chips on the peripheral byte bus
`timescale 1ns/1ps
`default_nettype none
module gbm_slave_model
   import gbm_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Bus driven by the master
   input wire logic [GBM_SLAVES-1:0] slave_select_n,
   input wire logic [GBM_REG_W-1:0] slave_reg_addr,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [GBM_DATA_W-1:0] slave_data_o,
   input wire logic slave_data_oe,
   // Answers to the master
   output logic [GBM_DATA_W-1:0] slave_data_i,
   output logic slave_wait_n,
   // Wait clocks commanded by the scenario
   input wire logic [5:0] wait_clks
);
   logic [15:0] wr_log[$];
   logic [15:0] wr_last = 16'h0;
   logic st_q = 1'h1;
   logic wr_q = 1'h1;
   int hold = 0;

   initial begin
      slave_data_i = 8'h00;
      slave_wait_n = 1'h1;
   end

   // Hold wait from the start of each strobe, log writes, answer reads
   always @(posedge sys_clk) begin
      // Look once the master's outputs have settled after the edge
      #1;
      if (st_q && !(read_strobe_n && write_strobe_n)) hold = wait_clks;
      else if (read_strobe_n && write_strobe_n) hold = 0;
      else if (hold > 0) hold = hold - 1;
      if (!write_strobe_n)
         wr_last = {slave_select_n, slave_data_oe, slave_reg_addr, slave_data_o};
      if (!wr_q && write_strobe_n) wr_log.push_back(wr_last);
      st_q = read_strobe_n && write_strobe_n;
      wr_q = write_strobe_n;
      slave_wait_n = (hold == 0);
      // Released bus toggles so a stale byte never looks valid
      if (!read_strobe_n) slave_data_i = {~slave_select_n, 1'h1, slave_reg_addr};
      else slave_data_i = ~slave_data_i;
   end
endmodule : gbm_slave_model
`default_nettype wire

// *** guest_bus_master_mailbox_bench.sv ***
// Self-checking bench of the peripheral bus master
`timescale 1ns/1ps
`default_nettype none
module guest_bus_master_mailbox_bench
   import gbm_pkg::*;
;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic mbox_wr = 1'h0;
   logic [3:0] mbox_be = 4'hf;
   logic [31:0] mbox_wdata = 32'h0;
   logic [31:0] mbox_rdata;
   logic [7:0] strobe_width = 8'he4;
   logic [7:0] strobe_recovery = 8'h1b;
   logic [1:0] stream_target_id = 2'h1;
   logic [2:0] stream_target_reg = 3'h5;
   logic code_valid = 1'h0;
   logic code_ready;
   logic [31:0] code_word = 32'h0;
   logic stream_timeout;
   logic stream_timeout_clr = 1'h0;
   logic [3:0] slave_select_n;
   logic [2:0] slave_reg_addr;
   logic read_strobe_n;
   logic write_strobe_n;
   logic [7:0] slave_data_i;
   logic [7:0] slave_data_o;
   logic slave_data_oe;
   logic slave_wait_n;
   logic slave_ready_in = 1'h1;
   logic [5:0] wait_clks = 6'h00;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int tab [4] = '{3, 4, 12, 15};
   int lowc = 0;
   int gapc = 99;
   int last_low = 0;
   int cur_id = 0;
   int last_id = 0;
   logic st;
   logic st_q = 1'h1;
   logic st_qq = 1'h1;
   logic [3:0] sel_q = 4'hf;

   gbm_master uut (.sys_clk, .sys_rst, .mbox_wr, .mbox_be, .mbox_wdata,
      .mbox_rdata, .strobe_width, .strobe_recovery, .stream_target_id,
      .stream_target_reg, .code_valid, .code_ready, .code_word,
      .stream_timeout, .stream_timeout_clr, .slave_select_n, .slave_reg_addr,
      .read_strobe_n, .write_strobe_n, .slave_data_i, .slave_data_o,
      .slave_data_oe, .slave_wait_n, .slave_ready_in);
   gbm_slave_model partner (.sys_clk, .slave_select_n, .slave_reg_addr,
      .read_strobe_n, .write_strobe_n, .slave_data_o, .slave_data_oe,
      .slave_data_i, .slave_wait_n, .wait_clks);

   // Clock and hang limit
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic print_verdict;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict

   function automatic int id_of(input logic [3:0] s);
      for (int i = 3; i >= 0; i--) if (!s[i]) return i;
      return 0;
   endfunction : id_of

   function automatic logic [31:0] mw(input logic d, input logic [1:0] id,
      input logic [2:0] r, input logic [7:0] b);
      return {15'h0, d, 2'h0, id, 1'h0, r, b};
   endfunction : mw

   function automatic logic [15:0] ent(input logic [1:0] id,
      input logic [2:0] r, input logic [7:0] b);
      return {~(4'h1 << id), 1'h1, r, b};
   endfunction : ent

   // Strobe width, recovery and select framing on every access
   always @(negedge sys_clk) begin
      if (!sys_rst) begin
         st = read_strobe_n & write_strobe_n;
         if (!st) lowc++;
         else gapc++;
         if (st_q && !st) begin
            cur_id = id_of(slave_select_n);
            chk(sel_q !== 4'hf, "strobe before select");
            chk($countones(~slave_select_n) == 1, "select count");
            chk(read_strobe_n || !slave_data_oe, "drive on read");
            chk(gapc >= tab[strobe_recovery[2*last_id+:2]], "recovery");
            gapc = 0;
         end
         if (!st_q && st) begin
            chk(lowc >= tab[strobe_width[2*cur_id+:2]], "width");
            last_low = lowc;
            last_id = cur_id;
            lowc = 0;
         end
         if (slave_select_n === 4'hf && sel_q !== 4'hf)
            chk(st_q && !st_qq, "select release");
         st_qq = st_q;
         st_q = st;
         sel_q = slave_select_n;
      end
   end

   task automatic mbox_op(input logic [31:0] w);
      int k;
      @(posedge sys_clk) #1;
      mbox_wr = 1'h1;
      mbox_wdata = w;
      @(posedge sys_clk) #1;
      mbox_wr = 1'h0;
      @(posedge sys_clk) #1;
      chk(mbox_rdata[24] === 1'h1, "pending not set");
      for (k = 0; k < 300 && mbox_rdata[24] !== 1'h0; k++) @(posedge sys_clk) #1;
      chk(mbox_rdata[24] === 1'h0, "pending stuck");
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : mbox_op

   task automatic push_word(input logic [31:0] w, output logic ok);
      @(posedge sys_clk) #1;
      code_valid = 1'h1;
      code_word = w;
      ok = 1'h0;
      for (int k = 0; k < 10 && !ok; k++) begin
         ok = (code_ready === 1'h1);
         @(posedge sys_clk);
      end
      #1 code_valid = 1'h0;
   endtask : push_word

   task automatic wait_log(input int n);
      for (int k = 0; k < 3000 && partner.wr_log.size() < n; k++)
         @(posedge sys_clk);
      #1;
   endtask : wait_log

   task automatic sc_mbox;
      int n;
      for (int i = 0; i < 4; i++) begin
         mbox_op(mw(1'h1, 2'(i), 3'(i + 3), 8'(8'h5a + i)));
         chk(partner.wr_log[$] === ent(2'(i), 3'(i + 3), 8'(8'h5a + i)),
            "mailbox write");
         n = partner.wr_log.size();
         mbox_op(mw(1'h0, 2'(i), 3'(7 - i), 8'h00));
         chk(mbox_rdata[7:0] === {4'(1 << i), 1'h1, 3'(7 - i)},
            "mailbox read");
         chk(partner.wr_log.size() == n, "read wrote");
      end
   endtask : sc_mbox

   task automatic sc_wait;
      wait_clks = 6'h06;
      mbox_op(mw(1'h0, 2'h0, 3'h5, 8'h00));
      chk(mbox_rdata[7:0] === 8'h1d, "read under wait");
      chk(last_low >= 8, "wait ignored");
   endtask : sc_wait

   task automatic sc_stream;
      int n;
      int k;
      logic ok;
      logic [31:0] w [3];
      w = '{32'h04030201, 32'h8c7b6a59, 32'hf0e1d2c3};
      slave_ready_in = 1'h0;
      wait_clks = 6'h02;
      n = partner.wr_log.size();
      k = 0;
      for (int j = 0; j < 3; j++) begin
         push_word(w[j], ok);
         if (ok) k++;
      end
      chk(k == 2, "buffer depth");
      repeat (20) @(posedge sys_clk);
      chk(partner.wr_log.size() == n, "code while not ready");
      slave_ready_in = 1'h1;
      wait_log(n + 8);
      for (int b = 0; b < 8; b++)
         chk(partner.wr_log[n + b] === ent(2'h1, 3'h5, w[b/4][8*(b%4)+:8]),
            "code byte");
   endtask : sc_stream

   task automatic sc_preempt;
      int n;
      int p;
      logic ok;
      wait_clks = 6'h00;
      n = partner.wr_log.size();
      push_word(32'h33221100, ok);
      push_word(32'h77665544, ok);
      for (int k = 0; k < 200 && write_strobe_n !== 1'h0; k++)
         @(posedge sys_clk) #1;
      mbox_op(mw(1'h1, 2'h3, 3'h2, 8'hc3));
      wait_log(n + 9);
      p = -1;
      for (int j = 0; j < 9; j++)
         if (partner.wr_log[n + j] === ent(2'h3, 3'h2, 8'hc3)) p = j;
      chk(p == 1, "mailbox not next");
   endtask : sc_preempt

   task automatic sc_abort;
      int n;
      logic ok;
      wait_clks = 6'h3f;
      mbox_op(mw(1'h1, 2'h0, 3'h1, 8'h11));
      chk(mbox_rdata[25] === 1'h1, "no mailbox timeout");
      chk(last_low >= 32 && last_low <= 33, "abort length");
      n = partner.wr_log.size();
      push_word(32'hdeadbeef, ok);
      wait_log(n + 4);
      chk(stream_timeout === 1'h1, "no stream timeout");
      wait_clks = 6'h00;
      stream_timeout_clr = 1'h1;
      @(posedge sys_clk) #1;
      stream_timeout_clr = 1'h0;
      @(posedge sys_clk) #1;
      chk(stream_timeout === 1'h0, "timeout kept");
      mbox_op(mw(1'h1, 2'h2, 3'h0, 8'h3c));
      chk(mbox_rdata[25] === 1'h0, "mailbox timeout kept");
   endtask : sc_abort

   // Reset, then every scenario in turn
   initial begin
      repeat (3) @(posedge sys_clk);
      #1 sys_rst = 1'h0;
      chk(mbox_rdata === 32'h0 && slave_select_n === 4'hf, "reset");
      @(posedge sys_clk) #1;
      chk(code_ready === 1'h1, "buffer not ready");
      sc_mbox();
      sc_wait();
      sc_stream();
      sc_preempt();
      sc_abort();
      print_verdict();
   end
endmodule : guest_bus_master_mailbox_bench
`default_nettype wire
